// *** mimb_top.sv ***
// Purpose: two interrupt mask banks, one for the fan tach channels and one
//          for the remaining monitor sources, each bit gating one source except misc bits 5 and 7
// Assumes: register port is synchronous to clk; write strobe is one cycle;
//          source events are already synchronous to clk
// Notes:   read data is registered, one cycle after the read strobe;
//          gating is combinational and stores no event, so a mask set
//          while a source is active hides it and clearing shows it again;
//          status latching and the interrupt pin live outside this block
module mimb_top #(
    parameter int unsigned TACH_N = 8                      // fan tach channels
) (
    input  wire logic              clk,                   // 20 MHz device clock
    input  wire logic              sys_rst,               // asynchronous, active high
    input  wire logic [7:0]        reg_addr,              // register index
    input  wire logic              reg_wr,                // write strobe
    input  wire logic [7:0]        reg_wdata,             // write data
    input  wire logic              reg_rd,                // read strobe
    output logic      [7:0]        reg_rdata,             // registered read data
    output logic                   reg_hit,               // address hits a mask bank
    input  wire logic [TACH_N-1:0] tach_event,            // fan tach limit events
    input  wire logic              int_temp_event,        // internal temperature event
    input  wire logic              battery_event,         // battery voltage event
    input  wire logic              ain8_event,            // analog input 8 event
    input  wire logic              overtemp_alarm_signal, // overtemperature alarm event
    input  wire logic              auto_cool_event,       // automatic cooling event
    input  wire logic              enclosure_event,       // enclosure intrusion event
    output logic      [TACH_N-1:0] tach_irq_req,          // unmasked tach events
    output logic      [6:0]        misc_irq_req           // unmasked misc events, bit 5 zero
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks
    // the fan bank is one byte and every bit gates one channel, so any
    // other channel count would leave masks without sources or sources
    // without masks; refuse it while elaborating instead of mis-gating
    generate
        if (TACH_N != mimb_pkg::REG_W) begin : gen_bad_tach_n
            $error("mimb_top: TACH_N must equal the register width");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // mask storage
    logic [7:0] interrupt_mask_group3_reg;    // fan tach masks, one bit a channel
    logic [7:0] interrupt_mask_group3_next;   // next value of the fan bank
    logic [7:0] interrupt_mask_group4_reg;    // misc source masks
    logic [7:0] interrupt_mask_group4_next;   // next value of the misc bank
    logic [7:0] rdata_next;                   // read mux result
    logic       wr_group3;                    // write to the fan bank this cycle
    logic       wr_group4;                    // write to the misc bank this cycle

    // address decode, shared by the write, read and hit paths
    function automatic logic is_addr(
        input logic [7:0] a,     // index on the register port
        input logic [7:0] ofs    // index of one bank
    );
        is_addr = (a == ofs);
    endfunction

    // per-bank write enables; a write to any other index is dropped
    assign wr_group3 = reg_wr & is_addr(reg_addr, mimb_pkg::OFS_MASK_GRP3);
    assign wr_group4 = reg_wr & is_addr(reg_addr, mimb_pkg::OFS_MASK_GRP4);

    // next mask values: a write replaces the whole bank; there is no
    // per-bit set or clear, so software rewrites the full byte to change
    // one source and must keep its own copy of the other bits
    always_comb begin
        interrupt_mask_group3_next = interrupt_mask_group3_reg;   // hold by default
        interrupt_mask_group4_next = interrupt_mask_group4_reg;   // hold by default
        if (wr_group3) begin
            interrupt_mask_group3_next = reg_wdata;
        end
        if (wr_group4) begin
            // bit 5 and bit 7 store nothing, so they read back zero
            interrupt_mask_group4_next = reg_wdata & mimb_pkg::GRP4_IMPL_MASK;
        end
    end

    // mask registers only; both banks power up with every source passing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            interrupt_mask_group3_reg <= mimb_pkg::RST_MASK_GRP3;
            interrupt_mask_group4_reg <= mimb_pkg::RST_MASK_GRP4;
        end else begin
            interrupt_mask_group3_reg <= interrupt_mask_group3_next;
            interrupt_mask_group4_reg <= interrupt_mask_group4_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read path
    // the mux looks at the banks as they stand before the edge, so a read
    // and a write in one cycle return the old value of the bank
    always_comb begin
        rdata_next = reg_rdata;                                   // stands until the next read
        if (reg_rd) begin
            if (is_addr(reg_addr, mimb_pkg::OFS_MASK_GRP3)) begin
                rdata_next = interrupt_mask_group3_reg;
            end else if (is_addr(reg_addr, mimb_pkg::OFS_MASK_GRP4)) begin
                rdata_next = interrupt_mask_group4_reg;
            end else begin
                rdata_next = mimb_pkg::RDATA_IDLE;                // unmapped index
            end
        end
    end

    // read data register; it stands until the next read strobe, so a slow
    // host may pick it up at leisure
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= mimb_pkg::RDATA_IDLE;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // hit flag for the surrounding register file; combinational, it
    // follows the index in the same cycle and needs no strobe
    assign reg_hit = is_addr(reg_addr, mimb_pkg::OFS_MASK_GRP3) |
                     is_addr(reg_addr, mimb_pkg::OFS_MASK_GRP4);

    ////////////////////////////////////////////////////////////////////////
    // named mask fields of the fan bank, one per tach channel
    logic              tach0_irq_mask;   // channel 0 blocked
    logic              tach1_irq_mask;   // channel 1 blocked
    logic              tach2_irq_mask;   // channel 2 blocked
    logic              tach3_irq_mask;   // channel 3 blocked
    logic              tach4_irq_mask;   // channel 4 blocked
    logic              tach5_irq_mask;   // channel 5 blocked
    logic              tach6_irq_mask;   // channel 6 blocked
    logic              tach7_irq_mask;   // channel 7 blocked
    logic [TACH_N-1:0] tach_mask;        // fan masks as a vector

    // bit n of the fan bank belongs to channel n
    assign tach0_irq_mask = interrupt_mask_group3_reg[0];
    assign tach1_irq_mask = interrupt_mask_group3_reg[1];
    assign tach2_irq_mask = interrupt_mask_group3_reg[2];
    assign tach3_irq_mask = interrupt_mask_group3_reg[3];
    assign tach4_irq_mask = interrupt_mask_group3_reg[4];
    assign tach5_irq_mask = interrupt_mask_group3_reg[5];
    assign tach6_irq_mask = interrupt_mask_group3_reg[6];
    assign tach7_irq_mask = interrupt_mask_group3_reg[7];

    // back into a vector for the gate, channel 0 in bit 0
    assign tach_mask = {tach7_irq_mask, tach6_irq_mask, tach5_irq_mask, tach4_irq_mask,
                        tach3_irq_mask, tach2_irq_mask, tach1_irq_mask, tach0_irq_mask};

    ////////////////////////////////////////////////////////////////////////
    // named mask fields of the misc bank
    logic       int_temp_irq_mask;          // internal temperature blocked
    logic       battery_voltage_irq_mask;   // battery voltage blocked
    logic       analog_input_8_irq_mask;    // analog input 8 blocked
    logic       overtemp_alarm_irq_mask;    // overtemperature alarm blocked
    logic       auto_cooling_irq_mask;      // automatic cooling blocked
    logic       enclosure_open_irq_mask;    // enclosure intrusion blocked
    logic [6:0] misc_mask;                  // misc masks in bank bit order
    logic [6:0] misc_raw;                   // misc sources in bank bit order

    // field positions come from the package; bit 5 and bit 7 have no source
    assign int_temp_irq_mask        = interrupt_mask_group4_reg[mimb_pkg::BIT_INT_TEMP];
    assign battery_voltage_irq_mask = interrupt_mask_group4_reg[mimb_pkg::BIT_BATTERY];
    assign analog_input_8_irq_mask  = interrupt_mask_group4_reg[mimb_pkg::BIT_AIN8];
    assign overtemp_alarm_irq_mask  = interrupt_mask_group4_reg[mimb_pkg::BIT_OVERTEMP];
    assign auto_cooling_irq_mask    = interrupt_mask_group4_reg[mimb_pkg::BIT_AUTO_COOL];
    assign enclosure_open_irq_mask  = interrupt_mask_group4_reg[mimb_pkg::BIT_ENCLOSURE];

    // misc masks in bank bit order; the unused bit 5 never masks anything
    always_comb begin
        misc_mask                                = 7'h00;
        misc_mask[mimb_pkg::BIT_INT_TEMP]  = int_temp_irq_mask;
        misc_mask[mimb_pkg::BIT_BATTERY]   = battery_voltage_irq_mask;
        misc_mask[mimb_pkg::BIT_AIN8]      = analog_input_8_irq_mask;
        misc_mask[mimb_pkg::BIT_OVERTEMP]  = overtemp_alarm_irq_mask;
        misc_mask[mimb_pkg::BIT_AUTO_COOL] = auto_cooling_irq_mask;
        misc_mask[mimb_pkg::BIT_ENCLOSURE] = enclosure_open_irq_mask;
    end

    // misc sources in bank bit order; bit 5 has no source and stays low
    always_comb begin
        misc_raw                           = 7'h00;
        misc_raw[mimb_pkg::BIT_INT_TEMP]  = int_temp_event;
        misc_raw[mimb_pkg::BIT_BATTERY]   = battery_event;
        misc_raw[mimb_pkg::BIT_AIN8]      = ain8_event;
        misc_raw[mimb_pkg::BIT_OVERTEMP]  = overtemp_alarm_signal;
        misc_raw[mimb_pkg::BIT_AUTO_COOL] = auto_cool_event;
        misc_raw[mimb_pkg::BIT_ENCLOSURE] = enclosure_event;
    end

    ////////////////////////////////////////////////////////////////////////
    // gating
    // combinational so a cleared mask passes the very next event; the
    // trade is that a glitch on a source reaches the output unfiltered,
    // so sources are expected to come straight from flip-flops; a mask
    // never alters or clears the event itself, it only hides it
    mimb_gate #(
        .N         (TACH_N)
    ) u_tach_gate (
        .event_in  (tach_event),
        .mask      (tach_mask),
        .event_out (tach_irq_req)
    );

    // bit k of the misc bank blocks source k
    mimb_gate #(
        .N         (7)
    ) u_misc_gate (
        .event_in  (misc_raw),
        .mask      (misc_mask),
        .event_out (misc_irq_req)
    );
endmodule

// *** mimb_pkg.sv ***
// Purpose: constants for the monitor interrupt mask banks
// Assumes: byte-wide register port of the device's register file
// Notes:   one definition per number; code uses mimb_pkg::name
package mimb_pkg;
    localparam int unsigned REG_W          = 8;        // register width
    localparam int unsigned ADDR_W         = 8;        // register index width
    localparam logic [7:0]  OFS_MASK_GRP3  = 8'h1a;    // fan tach mask bank
    localparam logic [7:0]  OFS_MASK_GRP4  = 8'h1b;    // misc source mask bank
    localparam logic [7:0]  RST_MASK_GRP3  = 8'h00;    // power-on value, fan bank
    localparam logic [7:0]  RST_MASK_GRP4  = 8'h00;    // power-on value, misc bank
    localparam logic [7:0]  RDATA_IDLE     = 8'h00;    // read data at reset and for unmapped indices
    // field positions in group 4
    localparam int unsigned BIT_INT_TEMP   = 0;
    localparam int unsigned BIT_BATTERY    = 1;
    localparam int unsigned BIT_AIN8       = 2;
    localparam int unsigned BIT_OVERTEMP   = 3;
    localparam int unsigned BIT_AUTO_COOL  = 4;
    localparam int unsigned BIT_UNUSED     = 5;
    localparam int unsigned BIT_ENCLOSURE  = 6;
    localparam logic [7:0]  GRP4_IMPL_MASK = 8'h5f;    // bits that store a value
endpackage

// *** mimb_gate.sv ***
// Purpose: per-source mask gate; a set mask bit blocks that source
// Assumes: events are one-cycle pulses or levels from the measurement logic
// Notes:   purely combinational, no storage; the mask never alters the event
module mimb_gate #(
    parameter int unsigned N = 8
) (
    input  wire logic [N-1:0] event_in,   // raw source events
    input  wire logic [N-1:0] mask,       // one blocks a source
    output logic      [N-1:0] event_out   // events allowed to interrupt
);
    // a gate without sources makes no sense; refuse it while elaborating
    generate
        if (N == 0) begin : gen_bad_n
            $error("mimb_gate: N must be at least one");
        end
    endgenerate

    // gate each source by its own mask bit
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_gate
            assign event_out[g] = event_in[g] & ~mask[g];
        end
    endgenerate
endmodule

// *** mimb_monitor.sv ***
// Purpose: watch the mask banks at the top ports of the design
// Assumes: one clock domain; a write lands at the edge that takes it
// Notes:   sees only the top ports; expected masks come from the write data
module mimb_monitor #(
    parameter int unsigned TACH_N = 8
) (
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic              reg_hit,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic [TACH_N-1:0] tach_event,
    input wire logic [TACH_N-1:0] tach_irq_req,
    input wire logic              int_temp_event,
    input wire logic              battery_event,
    input wire logic              ain8_event,
    input wire logic              overtemp_alarm_signal,
    input wire logic              auto_cool_event,
    input wire logic              enclosure_event,
    input wire logic [6:0]        misc_irq_req
);
    ////////////////////////////////////////////////////////////////////////
    // raw misc events in output bit order; bit 5 has no source
    wire logic [6:0] ev = {enclosure_event, 1'b0, auto_cool_event, overtemp_alarm_signal,
                           ain8_event, battery_event, int_temp_event};
    wire logic       w_fan = reg_wr && (reg_addr == mimb_pkg::OFS_MASK_GRP3);  // fan bank write taken
    wire logic       w_msc = reg_wr && (reg_addr == mimb_pkg::OFS_MASK_GRP4);  // misc bank write taken
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // a whole-bank compare also catches a bit that fails to clear again
    fan_gate_a: assert property (w_fan |=> tach_irq_req == (tach_event & ~$past(reg_wdata[TACH_N-1:0])))
        else $error("fan bank gating wrong");
    temp_block_a: assert property (w_msc && reg_wdata[0] |=> !misc_irq_req[0])
        else $error("temperature event not blocked");
    batt_block_a: assert property (w_msc && reg_wdata[1] |=> !misc_irq_req[1])
        else $error("battery event not blocked");
    ain8_block_a: assert property (w_msc && reg_wdata[2] |=> !misc_irq_req[2])
        else $error("analog input event not blocked");
    alarm_block_a: assert property (w_msc && reg_wdata[3] |=> !misc_irq_req[3])
        else $error("alarm event not blocked");
    cool_block_a: assert property (w_msc && reg_wdata[4] |=> !misc_irq_req[4])
        else $error("cooling event not blocked");
    encl_block_a: assert property (w_msc && reg_wdata[6] |=> !misc_irq_req[6])
        else $error("enclosure event not blocked");
    misc_pass_a: assert property (w_msc |=> misc_irq_req == (ev & ~$past(reg_wdata[6:0])))
        else $error("misc bank gating wrong");
    cover property (w_fan && reg_wdata != 8'h00);
    cover property (reg_rd && reg_addr == mimb_pkg::OFS_MASK_GRP4);
    cover property (overtemp_alarm_signal && !misc_irq_req[3]);
    cover property (reg_rd && !reg_hit ##1 reg_rdata == 8'h00);
endmodule
bind mimb_top mimb_monitor #(.TACH_N(TACH_N)) i_mon (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_hit               (reg_hit),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .tach_event            (tach_event),
    .tach_irq_req          (tach_irq_req),
    .int_temp_event        (int_temp_event),
    .battery_event         (battery_event),
    .ain8_event            (ain8_event),
    .overtemp_alarm_signal (overtemp_alarm_signal),
    .auto_cool_event       (auto_cool_event),
    .enclosure_event       (enclosure_event),
    .misc_irq_req          (misc_irq_req)
);

// *** testbench.sv ***
// Purpose: drive the mask banks through register calls and check gating
// Assumes: read data is settled one cycle after the read strobe
// Notes:   all inputs move on the falling edge, away from sampling
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] FAN = mimb_pkg::OFS_MASK_GRP3;   // fan tach bank index
    localparam logic [7:0] MSC = mimb_pkg::OFS_MASK_GRP4;   // misc bank index
    logic       clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_hit;  // control
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tach_event = 8'h00;           // stimulus
    logic [5:0] ev = 6'h00;                  // misc events, enclosure on top
    logic [7:0] reg_rdata, tach_irq_req;
    logic [6:0] misc_irq_req;
    int         n_mismatch = 0, compares = 0;
    mimb_top i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .tach_event(tach_event), .int_temp_event(ev[0]), .battery_event(ev[1]),
        .ain8_event(ev[2]), .overtemp_alarm_signal(ev[3]), .auto_cool_event(ev[4]),
        .enclosure_event(ev[5]), .tach_irq_req(tach_irq_req), .misc_irq_req(misc_irq_req));
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // one-cycle write strobe; mask acts from the next cycle
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // read strobe, then data is registered by the following edge; the hit
    // flag is looked at while the index still stands
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        `CHK(reg_rdata, e)
        `CHK(reg_hit, (a == FAN) || (a == MSC))
    endtask
    task end_sim;
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        rd(FAN, 8'h00);
        rd(MSC, 8'h00);
        rd(8'h16, 8'h00);
        // unmasked after reset: each output follows its own event only
        tach_event = 8'h3c;
        ev = 6'h2a;
        @(negedge clk);
        `CHK(tach_irq_req, 8'h3c)
        `CHK(misc_irq_req, 7'h4a)
        tach_event = 8'hff;
        ev = 6'h3f;
        // an asymmetric mask so a reversed bit order shows up
        wr(FAN, 8'h1e);
        `CHK(tach_irq_req, 8'he1)
        tach_event = 8'h0f;
        @(negedge clk);
        `CHK(tach_irq_req, 8'h01)
        rd(FAN, 8'h1e);
        wr(FAN, 8'h00);
        `CHK(tach_irq_req, 8'h0f)
        tach_event = 8'hff;
        // walk each misc bit; bit 5 stores nothing so it is skipped
        for (int i = 0; i < 7; i++) if (i != 5) begin
            wr(MSC, 8'h01 << i);
            `CHK(misc_irq_req, 7'h5f & ~(7'h01 << i))
            wr(MSC, 8'h00);
            `CHK(misc_irq_req, 7'h5f)
        end
        wr(MSC, 8'hff);
        `CHK(misc_irq_req, 7'h00)
        rd(MSC, 8'h5f);
        // read data stands while no read is made
        wr(MSC, 8'h00);
        `CHK(reg_rdata, 8'h5f)
        // reset in mid-run returns the fan bank and the read data to zero
        wr(FAN, 8'hff);
        `CHK(tach_irq_req, 8'h00)
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        `CHK(reg_rdata, 8'h00)
        `CHK(tach_irq_req, 8'hff)
        rd(FAN, 8'h00);
        end_sim;
    end
endmodule
